// [hdl/sog_map.vh]
// Purpose: Constants for the one-time mode and general bits register block
// Assumes: 16-bit serial frames already assembled by the frame interface
// Notes:   Frame layout, register addresses, field positions, timing
`ifndef SOG_MAP_VH
`define SOG_MAP_VH

// ==========================================================
// Frame layout
`define SOG_ADDR_HI        15
`define SOG_ADDR_LO        14
`define SOG_RSEL_BIT       13
`define SOG_RO_BIT         12
`define SOG_DATA_HI        11

// ==========================================================
// Frame register addresses
`define SOG_ADDR_OTM       2'h1
`define SOG_ADDR_GB0       2'h2
`define SOG_ADDR_GB1       2'h3

// ==========================================================
// One-time mode register fields
`define SOG_OTM_DEVMODE    9
`define SOG_OTM_FAULTEMU   8
`define SOG_OTM_LIMPHOME   7
`define SOG_OTM_USED_MASK  12'h380

// ==========================================================
// General bits 0 marker bit and defaults
`define SOG_GB0_MARK       11
`define SOG_ID_CODE_DEF    11'h0a5

// ==========================================================
// Operating mode codes seen on mode_i
`define SOG_MODE_STARTUP   3'h0
`define SOG_MODE_RESTART   3'h1
`define SOG_MODE_FLASH     3'h2
`define SOG_MODE_NORMAL    3'h3
`define SOG_MODE_STANDBY   3'h4
`define SOG_MODE_FAILSAFE  3'h5

// ==========================================================
// Timing
`define SOG_UV_LIMIT_MS    256
`define SOG_CLK_HZ         250000000
`define SOG_UV_CYCLES      (`SOG_UV_LIMIT_MS * (`SOG_CLK_HZ / 1000))

`endif

// [hdl/sog_regs.v]
// Purpose: One-time mode register and two general bits registers
// Assumes: Frames arrive as one-cycle strobes; battery power-on is rstn_i
// Notes:   Read data is registered and valid the cycle after the strobe
//
// Contract
// - One-time write, start-up only, until power loss
// - Address bits 15:14 select the register
// - Bit 13 picks enable or flag readback
// - Read-only bit blocks the write
// - Dev mode suppresses supervision except long undervoltage and bad mode code
// - Dev mode keeps code reset; watchdog fails interrupt
// - Mode register may clear dev mode anytime
// - Test pin high at power-on sets dev mode
// - Fault emulation drives gate from fault code
// - Limp-home decides inhibit bit on fail-safe
// - General writes only in start-up, restart, flash
// - General 0 frame readback selection by bit 13
// - General 1 frame readback selection by bit 13
// - General writes only when read-only bit clear
// - Twelve bits each, read back as written except the general 0 marker
// - Power-up loads identity code, marker zero
// - Marker bit stuck at one after first write
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sog_map.vh"

module sog_regs #(
	parameter [10:0] ID_CODE  = `SOG_ID_CODE_DEF, // Arbitrary value
	parameter        UV_LIMIT = `SOG_UV_CYCLES
) (
	// Clock and battery power-on reset
	input  wire        clk_i,
	input  wire        rstn_i,
	// Frame port
	input  wire [1:0]  addr_i,
	input  wire [15:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [15:0] rdata_o,
	// Readback sources held elsewhere
	input  wire [15:0] irq_enable_readback_i,
	input  wire [15:0] irq_flag_readback_i,
	input  wire [15:0] sys_config_readback_i,
	input  wire [15:0] phy_config_readback_i,
	// Device status
	input  wire [2:0]  mode_i,
	input  wire        mode_reg_written_i,
	input  wire        dev_mode_clear_i,
	input  wire        test_pin_high_i,
	input  wire [3:0]  bus_fault_code_i,
	input  wire        enable_normal_i,
	input  wire        main_supply_uv_i,
	// Supervision events
	input  wire        wd_fail_i,
	input  wire        irq_timeout_i,
	input  wire        reset_mon_fail_i,
	input  wire        mode_code_bad_i,
	input  wire        failsafe_req_i,
	// Outputs
	output wire        dev_mode_o,
	output wire        limp_home_select_o,
	output wire        otm_locked_o,
	output reg         gate_o,
	output reg         reset_req_o,
	output reg         wd_irq_o,
	output reg         failsafe_go_o,
	output reg         inhibit_set_o,
	output reg         inhibit_clr_o
);

	// ==========================================================
	// State
	reg         devmode_reg;
	reg         faultemu_reg;
	reg         limp_reg;
	reg         otm_locked_reg;
	reg         strap_done_reg;
	reg  [11:0] gb0_reg;
	reg  [11:0] gb1_reg;
	reg  [31:0] uv_cnt_reg;
	reg         uv_long_reg;
	reg         failsafe_q_reg;

	// ==========================================================
	// Frame fields
	wire [15:0] wframe;
	wire [1:0]  fr_addr;
	wire        fr_rsel;
	wire        fr_ro;
	wire [11:0] fr_data;

	// ==========================================================
	// Decoded conditions
	wire        in_startup;
	wire        in_restart;
	wire        in_flash;
	wire        in_failsafe;
	wire        addr_match;
	wire        do_write;
	wire        otm_wr;
	wire        gb_window;
	wire        gb0_wr;
	wire        gb1_wr;
	wire        strap_window;
	wire        fs_entry;
	wire        rb_take;

	// ==========================================================
	// Next values
	wire [11:0] gb0_next;
	wire [11:0] gb1_next;
	wire [15:0] rb_otm;
	wire [15:0] rb_gb0;
	wire [15:0] rb_gb1;
	reg  [15:0] rd_next;
	wire        uv_expired;
	wire        sup_fault;
	wire        reset_next;
	wire        irq_next;
	wire        failsafe_next;
	wire        gate_next;

	// Power-on image of general bits 0: marker low, then identity code
	localparam [11:0] GB0_RESET = {1'b0, ID_CODE};
	localparam integer GB_BITS  = 12;

	// ==========================================================
	// Frame decode
	assign wframe  = wdata_i;
	assign fr_addr = wframe[`SOG_ADDR_HI:`SOG_ADDR_LO];
	assign fr_rsel = wframe[`SOG_RSEL_BIT];
	assign fr_ro   = wframe[`SOG_RO_BIT];
	assign fr_data = wframe[`SOG_DATA_HI:0];

	// ==========================================================
	// Operating mode decode
	assign in_startup  = (mode_i == `SOG_MODE_STARTUP);
	assign in_restart  = (mode_i == `SOG_MODE_RESTART);
	assign in_flash    = (mode_i == `SOG_MODE_FLASH);
	assign in_failsafe = (mode_i == `SOG_MODE_FAILSAFE);
	assign fs_entry    = in_failsafe & ~failsafe_q_reg;
	// strap looked at only on the first edge after reset
	assign strap_window = ~strap_done_reg;

	// ==========================================================
	// Write qualification
	// A frame whose address field disagrees with the port is refused
	assign addr_match = (fr_addr == addr_i);
	assign do_write = wr_i & ~fr_ro & addr_match;
	// start-up only, once per battery connect
	// A mode register write closes the window only while mode_reg_written_i stays high
	assign otm_wr = do_write & (addr_i == `SOG_ADDR_OTM) & in_startup &
		~otm_locked_reg & ~mode_reg_written_i;
	assign gb_window = in_startup | in_restart | in_flash;
	// write only with read-only bit clear
	assign gb0_wr = do_write & gb_window & (addr_i == `SOG_ADDR_GB0);
	assign gb1_wr = do_write & gb_window & (addr_i == `SOG_ADDR_GB1);

	// ==========================================================
	// Register outputs
	assign dev_mode_o         = devmode_reg;
	assign limp_home_select_o = limp_reg;
	assign otm_locked_o       = otm_locked_reg;

	// ==========================================================
	// One-time mode register: lock and stored fields
	// Reserved frame bits are ignored, not stored
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			faultemu_reg   <= 1'b0;
			limp_reg       <= 1'b0;
			otm_locked_reg <= 1'b0;
		end else if (otm_wr) begin
			otm_locked_reg <= 1'b1;
			faultemu_reg   <= wframe[`SOG_OTM_FAULTEMU];
			limp_reg       <= wframe[`SOG_OTM_LIMPHOME];
		end
	end

	// ==========================================================
	// Strap window: open for the first edge after reset only
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_done_reg <= 1'b0;
		end else begin
			strap_done_reg <= 1'b1;
		end
	end

	// ==========================================================
	// Development mode flag
	// Strap wins over a write or a clear in the same cycle
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			devmode_reg <= 1'b0;
		end else if (strap_window && test_pin_high_i) begin
			// test pin strap sets the flag
			devmode_reg <= 1'b1;
		end else if (otm_wr) begin
			devmode_reg <= wframe[`SOG_OTM_DEVMODE];
		end else if (dev_mode_clear_i) begin
			devmode_reg <= 1'b0;
		end
	end

	// ==========================================================
	// General bits next values
	// marker forced high after write
	assign gb0_next = {1'b1, fr_data[`SOG_DATA_HI-1:0]};
	assign gb1_next = fr_data;

	// ==========================================================
	// General bits registers, one flip-flop pair per bit
	genvar gi;
	generate
		for (gi = 0; gi < GB_BITS; gi = gi + 1) begin : g_gbit
			always @(posedge clk_i or negedge rstn_i) begin
				if (!rstn_i) begin
					gb0_reg[gi] <= GB0_RESET[gi];
					gb1_reg[gi] <= 1'b0;
				end else begin
					if (gb0_wr) begin
						gb0_reg[gi] <= gb0_next[gi];
					end
					if (gb1_wr) begin
						gb1_reg[gi] <= gb1_next[gi];
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// Readback sources
	// enable or flag readback
	assign rb_otm = fr_rsel ? irq_flag_readback_i :
		irq_enable_readback_i;
	// general 0 or system config readback
	assign rb_gb0 = fr_rsel ? {wframe[15:12], gb0_reg} :
		sys_config_readback_i;
	// general 1 or physical layer readback
	assign rb_gb1 = fr_rsel ? {wframe[15:12], gb1_reg} :
		phy_config_readback_i;

	// ==========================================================
	// Readback mux
	always @* begin
		rd_next = 16'h0000;
		case (addr_i)
			`SOG_ADDR_OTM: begin
				rd_next = rb_otm;
			end
			`SOG_ADDR_GB0: begin
				rd_next = rb_gb0;
			end
			`SOG_ADDR_GB1: begin
				rd_next = rb_gb1;
			end
			default: begin
				rd_next = 16'h0000;
			end
		endcase
	end

	// ==========================================================
	// Read data register
	// answer even when write refused
	assign rb_take = rd_i | wr_i;
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 16'h0000;
		end else if (rb_take) begin
			rdata_o <= rd_next;
		end else begin
			// Data stands for one cycle only
			rdata_o <= 16'h0000;
		end
	end

	// ==========================================================
	// Undervoltage timer
	// of the fail-safe causes, only a long main supply dip escapes dev mode
	assign uv_expired = (uv_cnt_reg >= UV_LIMIT);
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			uv_cnt_reg  <= 32'h00000000;
			uv_long_reg <= 1'b0;
		end else if (!main_supply_uv_i) begin
			uv_cnt_reg  <= 32'h00000000;
			uv_long_reg <= 1'b0;
		end else if (uv_expired) begin
			uv_long_reg <= 1'b1;
		end else begin
			uv_cnt_reg <= uv_cnt_reg + 32'h00000001;
		end
	end

	// ==========================================================
	// Supervision next values
	assign sup_fault = wd_fail_i | irq_timeout_i | reset_mon_fail_i;
	assign reset_next = mode_code_bad_i | (~devmode_reg & sup_fault);
	assign irq_next = devmode_reg & wd_fail_i;
	assign failsafe_next = uv_long_reg | (~devmode_reg & failsafe_req_i);
	// fault code drives gate when emulating
	assign gate_next = faultemu_reg ? (bus_fault_code_i == 4'h0) :
		enable_normal_i;

	// ==========================================================
	// Gate output
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gate_o <= 1'b0;
		end else begin
			gate_o <= gate_next;
		end
	end

	// ==========================================================
	// Reset request
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			reset_req_o <= 1'b0;
		end else begin
			reset_req_o <= reset_next;
		end
	end

	// ==========================================================
	// Watchdog interrupt request
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wd_irq_o <= 1'b0;
		end else begin
			wd_irq_o <= irq_next;
		end
	end

	// ==========================================================
	// Fail-safe request
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			failsafe_go_o <= 1'b0;
		end else begin
			failsafe_go_o <= failsafe_next;
		end
	end

	// ==========================================================
	// Fail-safe entry detector
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			failsafe_q_reg <= 1'b0;
		end else begin
			failsafe_q_reg <= in_failsafe;
		end
	end

	// ==========================================================
	// Inhibit bit control on fail-safe entry
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			inhibit_set_o <= 1'b0;
			inhibit_clr_o <= 1'b0;
		end else begin
			inhibit_set_o <= fs_entry & limp_reg;
			inhibit_clr_o <= fs_entry & ~limp_reg;
		end
	end

endmodule

`default_nettype wire

// [test/sog_regs_assertions.sv]
// Purpose: Port checks for the register block
// Assumes: One clock, async active-low reset
// Notes:   Bound to every sog_regs instance
`timescale 1ns/1ps
`default_nettype none
module sog_regs_chk (
	// Watched ports
	input wire logic        clk_i, rstn_i, wr_i, rd_i, wd_fail_i,
	input wire logic        mode_code_bad_i, dev_mode_clear_i, dev_mode_o,
	input wire logic        otm_locked_o, reset_req_o, wd_irq_o,
	input wire logic [1:0]  addr_i,
	input wire logic [2:0]  mode_i,
	input wire logic [15:0] wdata_i, rdata_o, irq_enable_readback_i,
	input wire logic [15:0] irq_flag_readback_i, sys_config_readback_i,
	input wire logic [15:0] phy_config_readback_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	wire logic acc = wr_i | rd_i;
	// ====
	// Readback selection
	property p_otm_rb;
		acc && addr_i == 2'h1 |=> rdata_o == ($past(wdata_i[13]) ?
			$past(irq_flag_readback_i) : $past(irq_enable_readback_i));
	endproperty
	a_otm_rb: assert property (p_otm_rb) else $error("otm readback");
	property p_gb0_rb;
		acc && addr_i == 2'h2 && !wdata_i[13]
			|=> rdata_o == $past(sys_config_readback_i);
	endproperty
	a_gb0_rb: assert property (p_gb0_rb) else $error("gb0 readback");
	property p_gb1_rb;
		acc && addr_i == 2'h3 && !wdata_i[13]
			|=> rdata_o == $past(phy_config_readback_i);
	endproperty
	a_gb1_rb: assert property (p_gb1_rb) else $error("gb1 readback");
	// ====
	// One-time lock and supervision
	property p_lock_why;
		$rose(otm_locked_o) |->
			$past(wr_i && addr_i == 2'h1 && !wdata_i[12] && mode_i == 3'h0);
	endproperty
	a_lock_why: assert property (p_lock_why) else $error("bad lock");
	property p_lock_hold;
		otm_locked_o |=> otm_locked_o;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("unlock");
	property p_dev_clr;
		dev_mode_clear_i && otm_locked_o |=> !dev_mode_o;
	endproperty
	a_dev_clr: assert property (p_dev_clr) else $error("dev clear");
	property p_bad_rst;
		dev_mode_o && mode_code_bad_i |=> reset_req_o;
	endproperty
	a_bad_rst: assert property (p_bad_rst) else $error("code reset");
	property p_wd_irq;
		dev_mode_o && wd_fail_i && !mode_code_bad_i
			|=> wd_irq_o && !reset_req_o;
	endproperty
	a_wd_irq: assert property (p_wd_irq) else $error("wd fail");
endmodule
bind sog_regs sog_regs_chk sog_regs_chk_inst (.*);
`default_nettype wire

// [test/sog_host.sv]
// Purpose: Host model issuing register frames
// Assumes: Caller starts each frame just after a rising edge
// Notes:   Strobes stay up until idle is called
`timescale 1ns/1ps
`default_nettype none
module sog_host (
	// Clock and frame port
	input  wire logic        clk_i,
	output var  logic [1:0]  addr_o,
	output var  logic [15:0] frame_o,
	output var  logic        wr_o, rd_o, mode_wr_o
);
	initial begin
		{addr_o, frame_o, wr_o, rd_o, mode_wr_o} = '0;
	end
	task automatic xfer(input logic w, input logic [15:0] f);
		if (f[15:14] == 2'h1) f = f & 16'hf380;
		addr_o <= f[15:14];
		frame_o <= f;
		wr_o <= w;
		rd_o <= !w;
		@(posedge clk_i);
	endtask
	task automatic idle();
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic init_wd();
		mode_wr_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// [test/sog_regs_tb.sv]
// Purpose: Self-checking bench for the register block
// Assumes: Host model drives frames, bench drives status
// Notes:   Readback sources change randomly per frame
`timescale 1ns/1ps
`default_nettype none
`include "sog_map.vh"
module sog_regs_tb;
	localparam logic [10:0] ID = 11'h3c6; // Arbitrary value
	logic clk_i = 0, rstn_i = 0, wr_i, rd_i, mode_reg_written_i, gate_o;
	logic dev_mode_clear_i = 0, test_pin_high_i = 0, wd_fail_i = 0;
	logic mode_code_bad_i = 0, dev_mode_o, limp_home_select_o, otm_locked_o;
	logic reset_req_o, wd_irq_o, failsafe_go_o, inhibit_set_o, inhibit_clr_o;
	logic [1:0] addr_i;
	logic [2:0] mode_i = 0;
	logic [3:0] bus_fault_code_i = 0;
	logic [15:0] wdata_i, rdata_o, irq_enable_readback_i, irq_flag_readback_i;
	logic [15:0] sys_config_readback_i, phy_config_readback_i;
	logic [11:0] gb [2:3];
	int seed = 32'h92f93da3, err_count = 0, compares = 0;
	logic enable_normal_i = 0, main_supply_uv_i = 0, failsafe_req_i = 0;
	wire logic irq_timeout_i = 1'b0, reset_mon_fail_i = 1'b0;
	sog_regs #(.ID_CODE(ID), .UV_LIMIT(16)) sog_regs_inst (.*);
	sog_host sog_host_inst (.clk_i(clk_i), .addr_o(addr_i), .frame_o(wdata_i),
		.wr_o(wr_i), .rd_o(rd_i), .mode_wr_o(mode_reg_written_i));
	always #2 clk_i = !clk_i;
	// ====
	// Expectation and checking
	function automatic logic [15:0] rb(input logic [15:0] f);
		case (f[15:13])
			3'b010: return irq_enable_readback_i;
			3'b011: return irq_flag_readback_i;
			3'b100: return sys_config_readback_i;
			3'b101: return {f[15:12], gb[2]};
			3'b110: return phy_config_readback_i;
			3'b111: return {f[15:12], gb[3]};
			default: return 16'h0;
		endcase
	endfunction
	task automatic chk(input string n, input logic [15:0] e, g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic op(input logic w, input logic [15:0] f);
		irq_enable_readback_i <= 16'($random(seed));
		irq_flag_readback_i <= 16'($random(seed));
		sys_config_readback_i <= 16'($random(seed));
		phy_config_readback_i <= 16'($random(seed));
		sog_host_inst.xfer(w, f);
		#1;
		chk("rdata", rb(f), rdata_o);
		if (w && !f[12] && f[15] && mode_i <= `SOG_MODE_FLASH)
			gb[f[15:14]] = f[11:0] | (f[14] ? 12'h0 : 12'h800);
	endtask
	task automatic fs_check(input logic s);
		mode_i <= `SOG_MODE_NORMAL;
		sog_host_inst.idle();
		mode_i <= `SOG_MODE_FAILSAFE;
		@(posedge clk_i);
		#1;
		chk("inh", {14'h0, s, !s}, {14'h0, inhibit_set_o, inhibit_clr_o});
	endtask
	task automatic results();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		err_count++;
		results();
	end
	// ====
	// Scenarios
	initial begin
		gb[2] = {1'b0, ID};
		gb[3] = 12'h0;
		{irq_enable_readback_i, irq_flag_readback_i} = '0;
		{sys_config_readback_i, phy_config_readback_i} = '0;
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		for (int i = 2; i < 8; i++) op(1'b0, {i[2:0], 13'h1000});
		$display("test readback done");
		mode_i <= 3'h1;
		op(1'b1, 16'h4380);
		mode_i <= 3'h0;
		op(1'b1, 16'h5380);
		op(1'b1, 16'h4380);
		op(1'b1, 16'h4000);
		sog_host_inst.idle();
		chk("otm", 16'h7, {13'h0, dev_mode_o, limp_home_select_o,
			otm_locked_o});
		sog_host_inst.init_wd();
		for (int i = 0; i < 4; i++) begin
			bus_fault_code_i <= i[0] ? 4'h0 : (4'($random(seed)) | 4'h1);
			repeat (2) @(posedge clk_i);
			#1;
			chk("gate", {15'h0, bus_fault_code_i == 4'h0}, {15'h0, gate_o});
		end
		for (int i = 0; i < 2; i++) begin
			wd_fail_i <= !i[0];
			mode_code_bad_i <= i[0];
			@(posedge clk_i);
			wd_fail_i <= 1'b0;
			mode_code_bad_i <= 1'b0;
			#1;
			chk("reset", {15'h0, i[0]}, {15'h0, reset_req_o});
			chk("wdirq", {15'h0, !i[0]}, {15'h0, wd_irq_o});
		end
		dev_mode_clear_i <= 1'b1;
		@(posedge clk_i);
		dev_mode_clear_i <= 1'b0;
		#1;
		chk("dev", 16'h0, {15'h0, dev_mode_o});
		$display("test one-time done");
		for (int m = 0; m < 6; m++) begin
			mode_i <= m[2:0];
			for (int i = 0; i < 4; i++)
				op(1'b1, {1'b1, i[0], 1'b0, i[1], 12'($random(seed))});
			op(1'b0, 16'hb000);
			op(1'b0, 16'hf000);
		end
		fs_check(1'b1);
		mode_i <= 3'h0;
		op(1'b1, 16'h8000);
		op(1'b0, 16'hb000);
		sog_host_inst.idle();
		$display("test general done");
		test_pin_high_i <= 1'b1;
		rstn_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rstn_i <= 1'b1;
		gb[2] = {1'b0, ID};
		gb[3] = 12'h0;
		repeat (2) @(posedge clk_i);
		test_pin_high_i <= 1'b0;
		#1;
		chk("strap", 16'h4, {13'h0, dev_mode_o, limp_home_select_o,
			otm_locked_o});
		op(1'b0, 16'hb000);
		sog_host_inst.idle();
		bus_fault_code_i <= 4'h5;
		enable_normal_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk("gate", 16'h1, {15'h0, gate_o});
		failsafe_req_i <= 1'b1;
		@(posedge clk_i);
		failsafe_req_i <= 1'b0;
		#1;
		chk("fsgo", 16'h0, {15'h0, failsafe_go_o});
		main_supply_uv_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		#1;
		chk("fsgo", 16'h1, {15'h0, failsafe_go_o});
		main_supply_uv_i <= 1'b0;
		fs_check(1'b0);
		$display("test power-on done");
		results();
	end
endmodule
`default_nettype wire
